// *** hdl/latm_defines.svh ***
// constants for the link aggregation trunk manager
`ifndef LATM_DEFINES_SVH
`define LATM_DEFINES_SVH
`define LATM_NPORT        8
`define LATM_PORT_W       3
`define LATM_NGRP         6
`define LATM_GID_W        3
`define LATM_MAX_ACT      4
`define LATM_GID_NONE     3'h0
`define LATM_GID_MIN      3'h1
`define LATM_GID_MAX      3'h6
`endif

// *** hdl/latm_pkg.sv ***
// types for the link aggregation trunk manager
package latm_pkg;
   // per-port member state
   typedef enum logic [2:0] {
      LATM_MS_IDLE    = 3'b001,
      LATM_MS_ACTIVE  = 3'b010,
      LATM_MS_STANDBY = 3'b100
   } latm_mstate_t;
   // static membership write command
   typedef struct packed {
      logic       valid;
      logic [2:0] port;
      logic [2:0] gid;
   } latm_scmd_t;
   // group-wide settings write
   typedef struct packed {
      logic       valid;
      logic [2:0] gid;
      logic [2:0] stp;
      logic [11:0] vlan;
      logic       igmp;
   } latm_gset_t;
   // per-group settings as applied
   typedef struct packed {
      logic [2:0]  stp;
      logic [11:0] vlan;
      logic        igmp;
   } latm_gcfg_t;
   // egress request
   typedef struct packed {
      logic        valid;
      logic [2:0]  gid;
      logic [47:0] da;
      logic [47:0] sa;
   } latm_egr_t;
endpackage

// *** hdl/latm_top.sv ***
// link aggregation trunk manager: membership, standby, settings and egress pick
//
// Function
// - at most six groups, each with at most four active members unless a static command moves an active port into a group already at four.
// - negotiation allowed on any port not in a static group.
// - over four negotiated ports with one peer: extras go standby, carry nothing.
// - failed active member of a dynamic group is replaced by a standby port.
// - dynamic group forms only when the peer also negotiates.
// - new dynamic group takes the lowest free group identifier.
// - static group identifiers accepted only from one to six.
// - traffic spread over active members; survivors take a failed member's share.
// - dynamic members must be full duplex at both ends.
// - spanning tree, VLAN and snooping settings apply to whole groups only.
// - static groups are set manually at both ends without negotiation.
`timescale 1ns/10ps
`include "latm_defines.svh"
module latm_top
(
   // clock, reset, enable
   input  wire logic                                 i_clk,
   input  wire logic                                 i_rst,
   input  wire logic                                 i_ce,
   // per-port link status and negotiation
   input  wire logic [`LATM_NPORT-1:0]               i_link_up,
   input  wire logic [`LATM_NPORT-1:0]               i_full_duplex,
   input  wire logic [`LATM_NPORT-1:0]               i_lacp_en,
   input  wire logic [`LATM_NPORT-1:0]               i_peer_lacp,
   input  wire logic [`LATM_NPORT*8-1:0]             i_peer_key,
   // static membership and group settings
   input  wire latm_pkg::latm_scmd_t                 i_scmd,
   input  wire latm_pkg::latm_gset_t                 i_gset,
   // egress selection
   input  wire latm_pkg::latm_egr_t                  i_egr,
   // status
   output logic [`LATM_NPORT-1:0]                    o_active,
   output logic [`LATM_NPORT-1:0]                    o_standby,
   output logic [`LATM_NPORT*`LATM_GID_W-1:0]        o_port_gid,
   output logic [`LATM_NGRP-1:0]                     o_grp_dyn,
   output logic                                      o_cmd_err,
   output logic [`LATM_NGRP*16-1:0]                  o_gcfg,
   output logic                                      o_egr_valid,
   output logic [`LATM_PORT_W-1:0]                   o_egr_port
);
   localparam int NP = `LATM_NPORT;
   localparam int NG = `LATM_NGRP;

   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      logic [NP-1:0]                     stat;     // port is static member
      logic [NP-1:0][2:0]                gid;      // group of each port, 0 none
      logic [NP-1:0]                     act;
      logic [NP-1:0]                     sby;
      logic [NG-1:0]                     dyn;      // group made by negotiation
      logic [NG-1:0][7:0]                gkey;     // peer key of dynamic group
      logic [NG-1:0]                     cfgd;     // static group in use
      latm_pkg::latm_gcfg_t [NG-1:0]     gcfg;
      logic                              err;
      logic                              ev;
      logic [2:0]                        ep;
   } latm_st_t;

   latm_st_t st_q;
   latm_st_t st_d;

   // count of bits set in a port vector
   function automatic logic [3:0] latm_cnt(input logic [NP-1:0] v);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < NP; i++)
         c = c + {3'h0, v[i]};
      return c;
   endfunction

   // n-th set bit of a port vector
   function automatic logic [2:0] latm_nth(input logic [NP-1:0] v, input logic [3:0] n);
      logic [3:0] c;
      logic [2:0] r;
      c = 4'h0;
      r = 3'h0;
      for (int i = 0; i < NP; i++)
         if (v[i])
         begin
            if (c == n)
               r = i[2:0];
            c = c + 4'h1;
         end
      return r;
   endfunction

   // ************************************************
   // next state
   // ************************************************
   always_comb
   begin
      logic [NP-1:0] ok;
      logic [NP-1:0] mem;
      logic [NG-1:0] used;
      logic [2:0]    fg;
      logic          fnd;
      logic [47:0]   h;
      logic [3:0]    na;
      logic [7:0]    k;
      ok   = '0;
      mem  = '0;
      used = '0;
      fg   = 3'h0;
      fnd  = 1'b0;
      h    = '0;
      na   = 4'h0;
      k    = 8'h00;
      st_d = st_q;
      st_d.ev  = 1'b0;
      st_d.err = 1'b0;
      // static membership commands
      if (i_scmd.valid)
      begin
         if (i_scmd.gid < `LATM_GID_MIN || i_scmd.gid > `LATM_GID_MAX)
            st_d.err = 1'b1;
         // group owned by negotiation, or the port itself negotiates
         else if (st_q.dyn[i_scmd.gid-3'h1] || i_lacp_en[i_scmd.port])
            st_d.err = 1'b1;
         else
         begin
            // manual membership, no negotiation involved
            st_d.stat[i_scmd.port] = 1'b1;
            st_d.gid[i_scmd.port]  = i_scmd.gid;
            st_d.cfgd[i_scmd.gid-3'h1] = 1'b1;
         end
      end
      // eligible negotiating ports: not static, full duplex, peer negotiating
      for (int p = 0; p < NP; p++)
         ok[p] = i_lacp_en[p] & ~st_d.stat[p] & i_full_duplex[p]
                 & i_peer_lacp[p] & i_link_up[p];
      // drop dynamic ports that lost eligibility
      for (int p = 0; p < NP; p++)
         if (!st_d.stat[p] && !ok[p])
            st_d.gid[p] = `LATM_GID_NONE;
      // dissolve empty dynamic groups, then rebuild used set
      for (int g = 0; g < NG; g++)
      begin
         mem = '0;
         for (int p = 0; p < NP; p++)
            mem[p] = (st_d.gid[p] == 3'(g + 1));
         if (st_d.dyn[g] && mem == '0)
            st_d.dyn[g] = 1'b0;
         used[g] = st_d.dyn[g] | st_d.cfgd[g];
      end
      // join or create groups for unassigned eligible ports
      for (int p = 0; p < NP; p++)
         if (ok[p] && st_d.gid[p] == `LATM_GID_NONE)
         begin
            k   = i_peer_key[p*8 +: 8];
            fnd = 1'b0;
            fg  = 3'h0;
            for (int g = 0; g < NG; g++)
               if (!fnd && st_d.dyn[g] && st_d.gkey[g] == k)
               begin
                  fnd = 1'b1;
                  fg  = 3'(g + 1);
               end
            // lowest free identifier for a new group
            for (int g = NG - 1; g >= 0; g--)
               if (!fnd && !used[g])
                  fg = 3'(g + 1);
            if (!fnd && fg != 3'h0)
            begin
               st_d.dyn[fg-3'h1]  = 1'b1;
               st_d.gkey[fg-3'h1] = k;
               used[fg-3'h1]      = 1'b1;
            end
            st_d.gid[p] = fg;
         end
      // active and standby selection per group
      for (int g = 0; g < NG; g++)
      begin
         mem = '0;
         for (int p = 0; p < NP; p++)
            mem[p] = (st_d.gid[p] == 3'(g + 1)) & i_link_up[p];
         // keep running actives, fill vacancies from other linked members in port order
         na = 4'h0;
         for (int p = 0; p < NP; p++)
            if (mem[p] && st_q.act[p] && na < `LATM_MAX_ACT)
               na = na + 4'h1;
         for (int p = 0; p < NP; p++)
            if (st_d.gid[p] == 3'(g + 1))
            begin
               st_d.act[p] = mem[p] & st_q.act[p];
               st_d.sby[p] = 1'b0;
            end
         for (int p = 0; p < NP; p++)
            if (mem[p] && !st_d.act[p])
            begin
               if (na < `LATM_MAX_ACT)
               begin
                  st_d.act[p] = 1'b1;
                  na = na + 4'h1;
               end
               else
                  st_d.sby[p] = st_d.dyn[g];
            end
      end
      for (int p = 0; p < NP; p++)
         if (st_d.gid[p] == `LATM_GID_NONE)
         begin
            st_d.act[p] = 1'b0;
            st_d.sby[p] = 1'b0;
         end
      // settings written per group only
      if (i_gset.valid && i_gset.gid >= `LATM_GID_MIN && i_gset.gid <= `LATM_GID_MAX)
      begin
         st_d.gcfg[i_gset.gid-3'h1].stp  = i_gset.stp;
         st_d.gcfg[i_gset.gid-3'h1].vlan = i_gset.vlan;
         st_d.gcfg[i_gset.gid-3'h1].igmp = i_gset.igmp;
      end
      // egress member pick by address hash over current actives
      if (i_egr.valid && i_egr.gid >= `LATM_GID_MIN && i_egr.gid <= `LATM_GID_MAX)
      begin
         mem = '0;
         for (int p = 0; p < NP; p++)
            mem[p] = (st_q.gid[p] == i_egr.gid) & st_q.act[p];
         na = latm_cnt(mem);
         h  = i_egr.da ^ i_egr.sa;
         k  = h[7:0] ^ h[15:8] ^ h[23:16] ^ h[31:24] ^ h[39:32] ^ h[47:40];
         if (na != 4'h0)
         begin
            st_d.ev = 1'b1;
            st_d.ep = latm_nth(mem, 4'(k % 8'(na)));
         end
      end
   end

   // ************************************************
   // register
   // ************************************************
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         st_q <= '0;
      else if (i_ce)
         st_q <= st_d;
   end

   // outputs straight from state
   assign o_active    = st_q.act;
   assign o_standby   = st_q.sby;
   assign o_port_gid  = st_q.gid;
   assign o_grp_dyn   = st_q.dyn;
   assign o_cmd_err   = st_q.err;
   assign o_gcfg      = st_q.gcfg;
   assign o_egr_valid = st_q.ev;
   assign o_egr_port  = st_q.ep;
endmodule // latm_top

// *** tb/latm_top_properties.sv ***
// port checker for the trunk manager
`timescale 1ns/10ps
`include "latm_defines.svh"
module latm_top_properties
(
   // clock and reset
   input wire logic                      i_clk,
   input wire logic                      i_rst,
   // inputs
   input wire logic                      i_ce,
   input wire logic [`LATM_NPORT-1:0]    i_link_up,
   input wire logic [`LATM_NPORT-1:0]    i_full_duplex,
   input wire logic [`LATM_NPORT-1:0]    i_lacp_en,
   input wire logic [`LATM_NPORT-1:0]    i_peer_lacp,
   input wire latm_pkg::latm_scmd_t      i_scmd,
   input wire latm_pkg::latm_gset_t      i_gset,
   input wire latm_pkg::latm_egr_t       i_egr,
   // outputs
   input wire logic [`LATM_NPORT-1:0]    o_active,
   input wire logic [`LATM_NPORT-1:0]    o_standby,
   input wire logic                      o_cmd_err,
   input wire logic [`LATM_NGRP*16-1:0]  o_gcfg,
   input wire logic                      o_egr_valid,
   input wire logic [`LATM_PORT_W-1:0]   o_egr_port
);
   // ****
   // checks
   // ****
   logic [`LATM_NPORT-1:0] act_q;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // active set as seen when an egress request is taken
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         act_q <= '0;
      else
         act_q <= o_active;
   act_stby_a: assert property (!(o_active & o_standby))
      else $error("port both active and standby");
   gid_range_a: assert property (i_ce && i_scmd.valid && (i_scmd.gid == 3'h0 ||
      i_scmd.gid == 3'h7) |=> o_cmd_err) else $error("bad static group id not refused");
   err_cause_a: assert property (o_cmd_err |-> $past(i_ce && i_scmd.valid))
      else $error("error pulse without a command");
   lacp_err_a: assert property (i_ce && i_scmd.valid && i_lacp_en[i_scmd.port]
      |=> o_cmd_err) else $error("negotiating port added to static group");
   egr_member_a: assert property (o_egr_valid |-> act_q[o_egr_port])
      else $error("egress port not an active member");
   link_act_a: assert property ($past(i_ce) |-> (o_active & ~$past(i_link_up)) == '0)
      else $error("port active with link down");
   neg_act_a: assert property ($past(i_ce) |-> (o_active & $past(i_lacp_en)
      & ~$past(i_peer_lacp & i_full_duplex)) == '0) else $error("dynamic member without peer");
   gcfg_cause_a: assert property ($changed(o_gcfg) |-> $past(i_ce && i_gset.valid))
      else $error("group settings changed without a write");
   cover property (o_egr_valid);
   cover property (|o_standby);
   cover property (o_cmd_err);
endmodule // latm_top_properties
bind latm_top latm_top_properties latm_top_properties_inst (.i_clk(i_clk), .i_rst(i_rst),
   .i_ce(i_ce), .i_link_up(i_link_up), .i_full_duplex(i_full_duplex), .i_lacp_en(i_lacp_en),
   .i_peer_lacp(i_peer_lacp), .i_scmd(i_scmd), .i_gset(i_gset), .i_egr(i_egr),
   .o_active(o_active), .o_standby(o_standby), .o_cmd_err(o_cmd_err), .o_gcfg(o_gcfg),
   .o_egr_valid(o_egr_valid), .o_egr_port(o_egr_port));

// *** tb/latm_peer.sv ***
// peer switch model on the far end of the aggregated links
`timescale 1ns/10ps
`include "latm_defines.svh"
module latm_peer
(
   // clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   // bench control
   input  wire logic [`LATM_NPORT-1:0]  i_neg,
   input  wire logic [`LATM_NPORT-1:0]  i_cut,
   // link side
   output logic [`LATM_NPORT-1:0]       o_link_up,
   output logic [`LATM_NPORT-1:0]       o_full_duplex,
   output logic [`LATM_NPORT-1:0]       o_peer_lacp,
   output logic [`LATM_NPORT*8-1:0]     o_peer_key
);
   // ****
   // link state
   // ****
   // negotiates only where told, always full duplex, one identity on every member
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         o_link_up     <= '0;
         o_full_duplex <= '0;
         o_peer_lacp   <= '0;
         o_peer_key    <= '0;
      end
      else
      begin
         o_link_up     <= ~i_cut;
         o_full_duplex <= '1;
         o_peer_lacp   <= i_neg & ~i_cut;
         o_peer_key    <= {`LATM_NPORT{8'h5a}};
      end
endmodule // latm_peer

// *** tb/test_latm_top.sv ***
// self-checking bench for the trunk manager
`timescale 1ns/10ps
`include "latm_defines.svh"
module test_latm_top;
   logic                 i_clk = 1'b0;
   logic                 i_rst = 1'b1;
   logic                 i_ce  = 1'b1;
   logic [7:0]           lacp = 8'h00, neg = 8'h00, cut = 8'h00, lnk, fdx, plc, act, stb;
   logic [63:0]          key;
   logic [23:0]          pgid;
   logic [5:0]           dyn;
   logic [95:0]          gcfg;
   logic                 err, ev;
   logic [2:0]           ep, p0;
   latm_pkg::latm_scmd_t scmd = '0;
   latm_pkg::latm_gset_t gset = '0;
   latm_pkg::latm_egr_t  egr = '0;
   int                   err_count = 0, num_checks = 0, i;
   // clock
   always #10 i_clk = ~i_clk;
   latm_peer latm_peer_inst (.i_clk(i_clk), .i_rst(i_rst), .i_neg(neg), .i_cut(cut),
      .o_link_up(lnk), .o_full_duplex(fdx), .o_peer_lacp(plc), .o_peer_key(key));
   latm_top latm_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_link_up(lnk),
      .i_full_duplex(fdx), .i_lacp_en(lacp), .i_peer_lacp(plc), .i_peer_key(key),
      .i_scmd(scmd), .i_gset(gset), .i_egr(egr), .o_active(act), .o_standby(stb),
      .o_port_gid(pgid), .o_grp_dyn(dyn), .o_cmd_err(err), .o_gcfg(gcfg),
      .o_egr_valid(ev), .o_egr_port(ep));
   // ****
   // tasks
   // ****
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic scmd_w(input logic [2:0] p, input logic [2:0] g);
      @(posedge i_clk) scmd <= {1'b1, p, g};
      @(posedge i_clk) scmd.valid <= 1'b0;
      #1;
   endtask
   task automatic egr_r(input logic [2:0] g, input logic [47:0] a);
      @(posedge i_clk) egr <= {1'b1, g, a, 48'h0};
      @(posedge i_clk) egr.valid <= 1'b0;
      #1;
   endtask
   task automatic results;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ****
   // tests
   // ****
   initial
   begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      scmd_w(3'h0, 3'h1);
      scmd_w(3'h1, 3'h1);
      chk("gid p1", 1, pgid[5:3]);
      chk("act", 8'h03, act);
      for (i = 0; i < 2; i++)
      begin
         scmd_w(3'h2, i ? 3'h7 : 3'h0);
         chk("err gid", 1, err);
      end
      @(posedge i_clk) lacp <= 8'hfc;
      scmd_w(3'h2, 3'h3);
      chk("err lacp", 1, err);
      repeat (20) @(posedge i_clk);
      chk("no group", 0, dyn);
      @(posedge i_clk) neg <= 8'hfc;
      for (i = 0; i < 50 && dyn[1] !== 1'b1; i++) @(posedge i_clk);
      repeat (4) @(posedge i_clk);
      #1;
      chk("dyn", 6'h02, dyn);
      chk("gid p2", 2, pgid[8:6]);
      chk("n act", 4, $countones(act[7:2]));
      chk("n stb", 2, $countones(stb));
      egr_r(3'h2, 48'h123456789abc);
      chk("egr v", 1, ev);
      chk("pick", 4, ep);
      p0 = ep;
      chk("member", 1, act[p0] & (pgid[p0*3+:3] == 3'h2));
      egr_r(3'h2, 48'h123456789abc);
      chk("flow", p0, ep);
      egr_r(3'h2, 48'h000000000001);
      chk("spread", 3, ep);
      egr_r(3'h0, 48'h1);
      chk("egr gid0", 0, ev);
      @(posedge i_clk) cut <= 8'h01 << p0;
      repeat (8) @(posedge i_clk);
      #1;
      chk("n act fail", 4, $countones(act[7:2]));
      chk("n stb fail", 1, $countones(stb));
      egr_r(3'h2, 48'h123456789abc);
      chk("moved", 1, ev & (ep != p0));
      chk("moved port", 5, ep);
      @(posedge i_clk) gset <= {1'b1, 3'h1, 3'h5, 12'h123, 1'b1};
      @(posedge i_clk) gset.valid <= 1'b0;
      #1;
      chk("gcfg g1", {3'h5, 12'h123, 1'b1}, gcfg[15:0]);
      chk("gcfg g2", 0, gcfg[31:16]);
      // enable low freezes state while the cut link comes back
      @(posedge i_clk) i_ce <= 1'b0;
      cut <= 8'h00;
      repeat (6) @(posedge i_clk);
      #1;
      chk("frozen stb", 1, $countones(stb));
      @(posedge i_clk) i_ce <= 1'b1;
      repeat (6) @(posedge i_clk);
      #1;
      chk("rejoin stb", 2, $countones(stb));
      chk("rejoin gid", 2, pgid[p0*3+:3]);
      results;
   end
   // watchdog
   initial
   begin
      repeat (3000) @(posedge i_clk);
      err_count++;
      results;
   end
endmodule // test_latm_top
